// *** logic/sdpsc_power_ctrl.sv ***
// Purpose: Device-side power-down and deep sleep state tracking
// Assumes: Controller keeps its own entry delays and clock-stop rules
// Notes: Decodes CKE, CS_n and CA0..CA2 on each rising link edge
`timescale 1ns/1ps
// Function
// - CKE low, CS low, CA=110 enters deep sleep
// - Deep sleep holds CKE low, buffers off
// - Array contents lost on deep sleep
// - CKE high exits; full init needed
// - Ready once two clocks and tXP have both passed
// - NOP needs stable CKE; two encodings
// - NOP never aborts running operation
// - CKE falls with CS high: power-down
module sdpsc_power_ctrl (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic cke,
  input wire logic csN,
  input wire logic [2:0] ca,
  input wire logic initDone,
  output sdpsc_pkg::sdpsc_stat_s status
);
  import sdpsc_pkg::*;

  typedef struct packed {
    sdpsc_state_e st;
    logic ckePrev;
    logic [7:0] xpCnt;
    logic [1:0] stableCnt;
    sdpsc_stat_s stat;
  } sdpsc_core_s;

  sdpsc_core_s core_r;
  sdpsc_core_s core_nxt;
  logic edgeSeen;
  sdpsc_pins_s pins;
  sdpsc_pins_s pinsRaw;
  logic isNop;
  logic isDeep;

  assign pinsRaw = '{cke: cke, csN: csN, ca: ca};

  // ----------------------------------------
  // Pin synchroniser and edge finder
  // ----------------------------------------
  sdpsc_edge_sync uSync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .linkClk(linkClk),
    .pinsIn(pinsRaw),
    .edgeSeen(edgeSeen),
    .pinsOut(pins)
  );

  // Command decode of the sampled edge
  assign isNop = (pins.cke == core_r.ckePrev) &&
    (pins.csN || (pins.ca == CA_NOP));
  assign isDeep = core_r.ckePrev && !pins.cke && !pins.csN &&
    ((pins.ca & CA_DEEP_MASK) == CA_DEEP);

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always_comb begin
    core_nxt = core_r;
    core_nxt.stat.nopSeen = 1'b0;
    core_nxt.stat.badSeq = 1'b0;
    if (core_r.xpCnt != 8'h00) begin
      core_nxt.xpCnt = core_r.xpCnt - 8'h01;
    end
    if (edgeSeen) begin
      core_nxt.ckePrev = pins.cke;
      core_nxt.stat.nopSeen = isNop;
      case (core_r.st)
        ST_IDLE: begin
          if (isDeep) begin
            core_nxt.st = ST_DEEP;
          end else if (core_r.ckePrev && !pins.cke && pins.csN) begin
            core_nxt.st = ST_PDOWN;
          end else if (core_r.ckePrev && !pins.cke) begin
            core_nxt.stat.badSeq = 1'b1;
          end
        end
        ST_PDOWN: begin
          if (pins.cke) begin
            core_nxt.st = ST_EXIT;
            core_nxt.xpCnt = TXP_CNT;
            core_nxt.stableCnt = STABLE_CNT;
          end
        end
        ST_DEEP: begin
          if (pins.cke) begin
            core_nxt.st = ST_UNINIT;
          end
        end
        ST_UNINIT: begin
          core_nxt.st = ST_UNINIT;
        end
        ST_EXIT: begin
          if (core_r.stableCnt != 2'h0) begin
            core_nxt.stableCnt = core_r.stableCnt - 2'h1;
          end
          if (!pins.csN) begin
            core_nxt.stat.badSeq = 1'b1;
          end
        end
        default: begin
          core_nxt.st = ST_IDLE;
        end
      endcase
    end
    if (core_r.st == ST_EXIT && core_r.xpCnt == 8'h00 &&
        core_r.stableCnt == 2'h0) begin
      core_nxt.st = ST_IDLE;
    end
    if (core_r.st == ST_UNINIT && initDone) begin
      core_nxt.st = ST_IDLE;
    end
    core_nxt.stat.inPowerDown = (core_nxt.st == ST_PDOWN);
    core_nxt.stat.inDeepSleep = (core_nxt.st == ST_DEEP);
    core_nxt.stat.needInit = (core_nxt.st == ST_UNINIT);
    core_nxt.stat.ready = (core_nxt.st == ST_IDLE);
    core_nxt.stat.buffersOn = (core_nxt.st != ST_DEEP) &&
      (core_nxt.st != ST_PDOWN);
    if (core_nxt.st == ST_DEEP) begin
      core_nxt.stat.arrayLost = 1'b1;
    end else if (core_nxt.st == ST_IDLE) begin
      core_nxt.stat.arrayLost = core_r.stat.arrayLost && !initDone;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_r <= '{st: ST_IDLE, ckePrev: 1'b1, xpCnt: 8'h00, stableCnt: 2'h0,
        stat: 8'h00};
    end else begin
      core_r <= core_nxt;
    end
  end

  assign status = core_r.stat;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_deep_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_IDLE && isDeep |=> status.inDeepSleep)
    else $error("deep sleep not entered");
  a_deep_exit_init: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_DEEP && pins.cke |=> status.needInit)
    else $error("deep sleep exit missed init");
  a_deep_buffers: assert property (@(posedge clk_sys) disable iff (!rstn)
    status.inDeepSleep |-> !status.buffersOn && status.arrayLost)
    else $error("buffers on in deep sleep");
  a_pdown_entry: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_IDLE && core_r.ckePrev && !pins.cke && pins.csN
    |=> status.inPowerDown)
    else $error("power-down not entered");
  a_exit_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_PDOWN && pins.cke |=> !status.ready [*8])
    else $error("ready before exit latency");
  a_nop_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && pins.cke != core_r.ckePrev |=> !status.nopSeen)
    else $error("nop flagged on CKE change");
  a_uninit_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    status.needInit && !initDone |=> !status.ready)
    else $error("ready without init");
  a_exit_cs: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_EXIT && !pins.csN |=> status.badSeq)
    else $error("command in exit not flagged");
  // Refusals, holds, NOP flag, power-down outputs and exit latency
  a_bad_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_IDLE && core_r.ckePrev && !pins.cke && !pins.csN &&
    !isDeep |=> status.badSeq && status.ready)
    else $error("bad entry not refused");
  a_deep_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    status.inDeepSleep && !(edgeSeen && pins.cke) |=> status.inDeepSleep)
    else $error("deep sleep left with CKE low");
  a_lost_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    status.needInit |-> status.arrayLost)
    else $error("array loss cleared before init");
  a_nop_keeps_pd: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_PDOWN && isNop |=> status.inPowerDown)
    else $error("nop ended power-down");
  a_nop_flag_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && isNop |=> status.nopSeen)
    else $error("nop not flagged");
  a_exit_latency: assert property (@(posedge clk_sys) disable iff (!rstn)
    core_r.st == ST_EXIT && core_r.xpCnt != 8'h00 |=> !status.ready)
    else $error("ready while exit latency runs");
  a_exit_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    edgeSeen && core_r.st == ST_PDOWN && pins.cke
    |=> core_r.xpCnt == TXP_CNT && core_r.stableCnt == STABLE_CNT)
    else $error("exit counters not loaded");
  a_pdown_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    status.inPowerDown |-> !status.buffersOn && !status.ready)
    else $error("buffers on in power-down");
  // Scenario covers
  c_refused: cover property (@(posedge clk_sys) disable iff (!rstn) status.badSeq);
  c_deep: cover property (@(posedge clk_sys) disable iff (!rstn) status.inDeepSleep);
  c_pdown: cover property (@(posedge clk_sys) disable iff (!rstn) status.inPowerDown);
  c_reinit: cover property (@(posedge clk_sys) disable iff (!rstn)
    status.needInit ##1 status.ready);
endmodule

// *** logic/sdpsc_pkg.sv ***
// Purpose: Shared constants and types for the SDRAM power-state decoder
// Assumes: Link clock sampled by clk_sys at 20 MHz
// Notes: All offsets, codes and timing counts live here
package sdpsc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_SYS_NS = 50;
  localparam int TXP_NS = 7500;
  localparam int TXP_CYC = (TXP_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
  localparam int STABLE_LINK_CLKS = 2;
  localparam logic [7:0] TXP_CNT = 8'(TXP_CYC);
  localparam logic [1:0] STABLE_CNT = 2'(STABLE_LINK_CLKS);
  localparam logic [3:0] PDN_CNT_MAX = 4'hf;

  // ----------------------------------------
  // Command codes on CA0..CA2
  // ----------------------------------------
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [2:0] CA_DEEP = 3'h3;
  localparam logic [2:0] CA_DEEP_MASK = 3'h7;

  // Power state of the device
  typedef enum logic [2:0] {
    ST_IDLE, ST_PDOWN, ST_DEEP, ST_UNINIT, ST_EXIT
  } sdpsc_state_e;

  // Pin sample of one rising link edge
  typedef struct packed {
    logic cke;
    logic csN;
    logic [2:0] ca;
  } sdpsc_pins_s;

  // Status outputs toward the core
  typedef struct packed {
    logic inPowerDown;
    logic inDeepSleep;
    logic needInit;
    logic ready;
    logic buffersOn;
    logic arrayLost;
    logic nopSeen;
    logic badSeq;
  } sdpsc_stat_s;
endpackage

// *** logic/sdpsc_edge_sync.sv ***
// Purpose: Synchronise link pins and flag each rising link clock edge
// Assumes: Pins change well away from the sampling edge
// Notes: First sync stage feeds only the second
`timescale 1ns/1ps
module sdpsc_edge_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic linkClk,
  input wire sdpsc_pkg::sdpsc_pins_s pinsIn,
  output logic edgeSeen,
  output sdpsc_pkg::sdpsc_pins_s pinsOut
);
  import sdpsc_pkg::*;

  typedef struct packed {
    logic [1:0] clkSync;
    logic clkPrev;
    sdpsc_pins_s pinA;
    sdpsc_pins_s pinB;
    logic edgeHit;
    sdpsc_pins_s pinHold;
  } sdpsc_sync_s;

  sdpsc_sync_s sync_r;
  sdpsc_sync_s sync_nxt;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    sync_nxt = sync_r;
    sync_nxt.clkSync = {sync_r.clkSync[0], linkClk};
    sync_nxt.clkPrev = sync_r.clkSync[1];
    sync_nxt.pinA = pinsIn;
    sync_nxt.pinB = sync_r.pinA;
    sync_nxt.edgeHit = sync_r.clkSync[1] & ~sync_r.clkPrev;
    if (sync_r.clkSync[1] & ~sync_r.clkPrev) begin
      sync_nxt.pinHold = sync_r.pinB;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign edgeSeen = sync_r.edgeHit;
  assign pinsOut = sync_r.pinHold;
endmodule

// *** tb/sdpsc_ctl_model.sv ***
// Purpose: Memory controller model driving link clock, CKE, CS_n and CA
// Assumes: Caller starts each frame at a falling clk_sys edge
// Notes: Link clock stands low between frames; a frame is 400 ns
`timescale 1ns/1ps
module sdpsc_ctl_model (
  input wire logic clk_sys,
  output logic linkClk,
  output logic cke,
  output logic csN,
  output logic [2:0] ca
);
  // Idle: clock stopped, deselected
  initial begin
    linkClk = 1'b0;
    cke = 1'b1;
    csN = 1'b1;
    ca = 3'h0;
  end
  // One link period, pins held six cycles past the rising edge
  task automatic frame(input logic k, input logic s, input logic [2:0] c);
    cke = k;
    csN = s;
    ca = s ? ~ca : c;
    // Fixed period, so latencies never need rewriting
    repeat (2) @(negedge clk_sys);
    linkClk = 1'b1;
    repeat (4) @(negedge clk_sys);
    linkClk = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
endmodule

// *** tb/test_sdpsc_power_ctrl.sv ***
// Purpose: Self-checking bench for the power-state decoder
// Assumes: Status settles within eight cycles of a link rising edge
// Notes: One-cycle status pulses are counted per frame
`timescale 1ns/1ps
module test_sdpsc_power_ctrl;
  import sdpsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic initDone = 1'b0;
  logic linkClk;
  logic cke;
  logic csN;
  logic [2:0] ca;
  sdpsc_stat_s status;
  int errors = 0;
  int n_checks = 0;
  int nops = 0;
  int bads = 0;
  // NOP link cycles between a command and CKE low, covering every entry delay
  localparam int ENTRY_GAP = 12;
  always #25 clk_sys = ~clk_sys;
  // Count status pulses away from the edge that launches them
  always @(negedge clk_sys) begin
    if (status.nopSeen === 1'b1) nops++;
    if (status.badSeq === 1'b1) bads++;
  end
  sdpsc_ctl_model sdpsc_ctl_model_i (.clk_sys(clk_sys), .linkClk(linkClk), .cke(cke),
    .csN(csN), .ca(ca));
  sdpsc_power_ctrl sdpsc_power_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .linkClk(linkClk),
    .cke(cke), .csN(csN), .ca(ca), .initDone(initDone), .status(status));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One frame, then let the status settle
  task automatic cmd(input logic k, input logic s, input logic [2:0] c);
    nops = 0;
    bads = 0;
    sdpsc_ctl_model_i.frame(k, s, c);
    repeat (2) @(negedge clk_sys);
  endtask
  // Bounded wait for ready
  task automatic wait_ready(input int lim);
    int n;
    for (n = 0; n < lim && status.ready !== 1'b1; n++) @(negedge clk_sys);
    if (status.ready !== 1'b1) begin
      errors++;
      stop_test();
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("reset", status, 8'h18);
    cmd(1'b1, 1'b1, 3'h0);
    check("nop deselect", 8'(nops), 8'h01);
    cmd(1'b1, 1'b0, CA_NOP);
    check("nop coded", 8'(nops), 8'h01);
    cmd(1'b1, 1'b0, 3'h1);
    check("not nop", 8'(nops), 8'h00);
    check("idle kept", status, 8'h18);
    repeat (ENTRY_GAP) cmd(1'b1, 1'b1, 3'h0);
    cmd(1'b0, 1'b1, 3'h0);
    check("pd enter", status, 8'h80);
    check("pd no nop", 8'(nops), 8'h00);
    cmd(1'b0, 1'b1, 3'h0);
    cmd(1'b0, 1'b1, 3'h0);
    repeat (20) @(negedge clk_sys);
    cmd(1'b0, 1'b1, 3'h0);
    cmd(1'b0, 1'b1, 3'h0);
    check("pd hold", status, 8'h80);
    check("pd nop", 8'(nops), 8'h01);
    cmd(1'b1, 1'b1, 3'h0);
    check("exit busy", 8'(status.ready), 8'h00);
    cmd(1'b1, 1'b0, 3'h1);
    check("exit refused", 8'(bads), 8'h01);
    cmd(1'b1, 1'b1, 3'h0);
    cmd(1'b1, 1'b1, 3'h0);
    repeat (80) @(negedge clk_sys);
    check("exit wait", 8'(status.ready), 8'h00);
    wait_ready(100);
    check("pd done", status, 8'h18);
    repeat (20) @(negedge clk_sys);
    cmd(1'b0, 1'b0, CA_DEEP);
    check("deep enter", status, 8'h44);
    cmd(1'b0, 1'b1, 3'h0);
    cmd(1'b0, 1'b1, 3'h0);
    check("deep hold", status, 8'h44);
    cmd(1'b1, 1'b1, 3'h0);
    check("deep exit", status, 8'h2c);
    initDone = 1'b1;
    @(negedge clk_sys);
    initDone = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("reinit", status, 8'h18);
    for (int c = 0; c < 8; c++) begin
      if (c != 3) begin
        cmd(1'b0, 1'b0, 3'(c));
        check("refused", 8'(bads), 8'h01);
        check("still idle", status, 8'h18);
        cmd(1'b1, 1'b1, 3'h0);
      end
    end
    stop_test();
  end
endmodule
